// ### inc/irq_mask_pkg.sv
// Package: constants and carrier types for the interrupt priority masking block
package irq_mask_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned NUM_SRC     = 8;
  localparam int unsigned SRC_IDX_W   = 3;
  localparam int unsigned PRIO_W      = 3;
  localparam int unsigned LEVEL_W     = 4;
  localparam int unsigned NUM_TRAP    = 8;
  localparam int unsigned BLOCK_CNT_W = 14;

  // ****************************************************************
  // Field positions and values
  // ****************************************************************
  localparam int unsigned     IPL_LSB         = 5;
  localparam int unsigned     IPL_MSB         = 7;
  localparam logic [2:0]      IPL_RESET       = 3'h0;
  localparam logic [2:0]      PRIO_RESET      = 3'h4;
  localparam logic [2:0]      PRIO_OFF        = 3'h0;
  localparam logic [2:0]      PRIO_MAX_BLOCK  = 3'h6;
  localparam logic [3:0]      TRAP_BASE_LEVEL = 4'h8;
  localparam logic [13:0]     BLOCK_CNT_RESET = 14'h0000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } status_wr_t;

  typedef struct packed {
    logic                 valid;
    logic [SRC_IDX_W-1:0] idx;
    logic [PRIO_W-1:0]    prio;
  } prio_wr_t;

  typedef struct packed {
    logic                   valid;
    logic [BLOCK_CNT_W-1:0] count;
  } block_cmd_t;

  typedef struct packed {
    logic                 valid;
    logic                 trap;
    logic [LEVEL_W-1:0]   level;
    logic [SRC_IDX_W-1:0] idx;
  } irq_req_t;

endpackage : irq_mask_pkg

// ### hw/interrupt_priority_masking.sv
// Interrupt priority masking: decides which trap or user request reaches the core
// Behaviour
// - Restored status word restores earlier level.
// - Level masking affects user priorities 1 to 7 only.
// - Traps 8 to 15 always presented.
// - Timed block hides priorities 1-6 temporarily.
// - Priority 7 passes during timed block.
// - Source priorities reset to 4.
// - Priority code 000 never presented.
`timescale 1ns/1ps
module interrupt_priority_masking
  import irq_mask_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire status_wr_t           status_wr_i,
  input  wire prio_wr_t             prio_wr_i,
  input  wire block_cmd_t           block_cmd_i,
  input  wire logic [NUM_SRC-1:0]   irq_i,
  input  wire logic [NUM_TRAP-1:0]  trap_i,
  output logic [2:0]                cpu_level_o,
  output logic                      block_active_o,
  output irq_req_t                  req_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0]                      ipl;
    logic [NUM_SRC-1:0][PRIO_W-1:0]  prio;
    logic [BLOCK_CNT_W-1:0]          block_cnt;
    logic                            block_on;
    irq_req_t                        req;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [NUM_SRC-1:0] elig;

  // Terms used only by the checks; they leave out the timed block or the level on purpose
  logic [NUM_SRC-1:0] seven_src;
  logic [NUM_SRC-1:0] open_src;

  // ****************************************************************
  // Per-source eligibility
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      always_comb begin
        elig[g] = irq_i[g]
                  && (st_r.prio[g] != PRIO_OFF)
                  && (st_r.prio[g] > st_r.ipl)
                  && !(st_r.block_on && (st_r.prio[g] <= PRIO_MAX_BLOCK));
        seven_src[g] = irq_i[g] && (st_r.prio[g] == 3'h7);
        open_src[g]  = irq_i[g] && (st_r.prio[g] > st_r.ipl);
      end
    end
  endgenerate

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [PRIO_W-1:0] best_p;
    best_p = PRIO_OFF;
    st_nxt = st_r;
    // A write of the status low byte covers both the raise and the restore
    if (status_wr_i.valid) begin
      st_nxt.ipl = status_wr_i.data[IPL_MSB:IPL_LSB];
    end
    if (prio_wr_i.valid) begin
      st_nxt.prio[prio_wr_i.idx] = prio_wr_i.prio;
    end
    // A new timed block restarts the count; it ends by itself at zero
    if (block_cmd_i.valid) begin
      st_nxt.block_on  = 1'b1;
      st_nxt.block_cnt = block_cmd_i.count;
    end else if (st_r.block_on) begin
      if (st_r.block_cnt == BLOCK_CNT_RESET) begin
        st_nxt.block_on = 1'b0;
      end else begin
        st_nxt.block_cnt = st_r.block_cnt - 14'h0001;
      end
    end
    st_nxt.req = '0;
    // Traps win over any user source and ignore level and timed block
    if (trap_i != '0) begin
      for (int i = 0; i < NUM_TRAP; i++) begin
        if (trap_i[i]) begin
          st_nxt.req.valid = 1'b1;
          st_nxt.req.trap  = 1'b1;
          st_nxt.req.level = TRAP_BASE_LEVEL + LEVEL_W'(i);
          st_nxt.req.idx   = SRC_IDX_W'(i);
        end
      end
    end else begin
      // Highest priority wins; ties go to the lowest index
      for (int i = 0; i < NUM_SRC; i++) begin
        if (elig[i] && (st_r.prio[i] > best_p)) begin
          best_p           = st_r.prio[i];
          st_nxt.req.valid = 1'b1;
          st_nxt.req.level = {1'b0, st_r.prio[i]};
          st_nxt.req.idx   = SRC_IDX_W'(i);
        end
      end
    end
    if (reset_i) begin
      st_nxt.ipl       = IPL_RESET;
      st_nxt.prio      = {NUM_SRC{PRIO_RESET}};
      st_nxt.block_cnt = BLOCK_CNT_RESET;
      st_nxt.block_on  = 1'b0;
      st_nxt.req       = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  assign cpu_level_o    = st_r.ipl;
  assign block_active_o = st_r.block_on;
  assign req_o          = st_r.req;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // A block of count four stands for five cycles after its command edge
  sequence s_block_start;
    block_cmd_i.valid && (block_cmd_i.count == 14'h0004);
  endsequence

  sequence s_block_quiet;
    !block_cmd_i.valid [*5];
  endsequence

  chk_trap_always: assert property ((trap_i != '0) |=> (req_o.valid && req_o.trap && req_o.level[3]))
    else $error("Trap request was not presented");

  chk_user_above_level: assert property (
    (req_o.valid && !req_o.trap) |-> (req_o.level[2:0] > cpu_level_o) || $past(status_wr_i.valid))
    else $error("User request presented at or below cpu level");

  chk_level_seven_mask: assert property (
    (cpu_level_o == 3'h7 && !$past(status_wr_i.valid)) |-> !(req_o.valid && !req_o.trap))
    else $error("User request passed level seven");

  chk_status_restore: assert property (status_wr_i.valid |=> cpu_level_o == $past(status_wr_i.data[7:5]))
    else $error("Cpu level not taken from status write");

  chk_block_lower: assert property (
    (block_active_o && req_o.valid && !req_o.trap && !$past(block_cmd_i.valid))
    |-> (req_o.level == 4'h7) || !$past(block_active_o))
    else $error("Priority 1-6 request passed during timed block");

  chk_block_ends: assert property (s_block_start ##1 s_block_quiet |=> !block_active_o)
    else $error("Timed block did not end after its count");

  chk_block_seven: assert property (
    (block_active_o && (cpu_level_o < 3'h7) && (trap_i == '0) && (seven_src != '0))
    |=> req_o.valid && (req_o.level == 4'h7))
    else $error("Priority 7 request blocked by timed block");

  chk_prio_off: assert property ((req_o.valid && !req_o.trap) |-> req_o.level != 4'h0)
    else $error("Disabled source presented");

  chk_reset_prio: assert property ($fell(reset_i) |-> st_r.prio[0] == 3'h4 && st_r.prio[NUM_SRC-1] == 3'h4)
    else $error("Source priority not four after reset");

  // ****************************************************************
  // Further checks
  // ****************************************************************
  chk_block_begins: assert property (block_cmd_i.valid |=> block_active_o)
    else $error("Timed block did not start on its command");

  chk_block_holds: assert property (
    (block_active_o && (st_r.block_cnt != BLOCK_CNT_RESET) && !block_cmd_i.valid) |=> block_active_o)
    else $error("Timed block ended before its count ran out");

  chk_user_range: assert property ((req_o.valid && !req_o.trap) |-> !req_o.level[3])
    else $error("User request above level seven");

  chk_trap_level: assert property (
    (req_o.valid && req_o.trap) |-> (req_o.level == {1'b1, req_o.idx}))
    else $error("Trap level does not match its index");

  chk_trap_top: assert property (trap_i[NUM_TRAP-1] |=> req_o.trap && (req_o.idx == 3'h7))
    else $error("Highest trap did not win");

  chk_trap_masked: assert property (((cpu_level_o == 3'h7) && (trap_i != '0)) |=> req_o.trap)
    else $error("Trap lost at cpu level seven");

  // Outside reset, a status write is the only way the level moves
  chk_level_hold: assert property (!status_wr_i.valid |=> $stable(cpu_level_o))
    else $error("Cpu level changed without a status write");

  chk_open_accept: assert property (
    ((trap_i == '0) && !block_active_o && (open_src != '0)) |=> req_o.valid && !req_o.trap)
    else $error("Source above cpu level was not presented");

  chk_closed_quiet: assert property (
    ((trap_i == '0) && (open_src == '0)) |=> !req_o.valid)
    else $error("Request presented with no source above cpu level");

  chk_prio_write: assert property (
    prio_wr_i.valid |=> (st_r.prio[$past(prio_wr_i.idx)] == $past(prio_wr_i.prio)))
    else $error("Source priority field not taken from its write");

endmodule : interrupt_priority_masking

// ### verification/cpu_core_model.sv
// Core model: writes the status low byte the way software masks and unmasks
`timescale 1ns/1ps
module cpu_core_model
  import irq_mask_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [1:0] cmd_i,
  input  wire logic [2:0] level_i,
  output status_wr_t      status_wr_o
);
  logic       wr_r     = 1'b0;
  logic [7:0] status_r = 8'h00;
  logic [7:0] saved_r  = 8'h00;
  // Data is scrambled outside a write so a stale byte is never trusted
  assign status_wr_o = {wr_r, wr_r ? status_r : ~status_r};
  always @(posedge clk_i) begin
    wr_r <= (cmd_i != 2'h0);
    case (cmd_i)
      2'h1: status_r <= {level_i, 5'h00};
      2'h2: begin
        saved_r  <= status_r;
        status_r <= status_r | 8'hE0;
      end
      2'h3: status_r <= saved_r;
      default: ;
    endcase
  end
endmodule : cpu_core_model

// ### verification/tb.sv
// Testbench: masking, restore, traps and timed block seen at the request port
`timescale 1ns/1ps
module tb;
  import irq_mask_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  status_wr_t status_wr;
  prio_wr_t prio_wr = '0;
  block_cmd_t block_cmd = '0;
  logic [7:0] irq = 8'h00;
  logic [7:0] trap = 8'h00;
  logic [2:0] cpu_level;
  logic block_active;
  irq_req_t req;
  logic [1:0] cmd = 2'h0;
  logic [2:0] lv = 3'h0;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  always #10 clk_i = ~clk_i;
  cpu_core_model i_core (.clk_i(clk_i), .cmd_i(cmd), .level_i(lv), .status_wr_o(status_wr));
  interrupt_priority_masking i_dut (.clk_i(clk_i), .reset_i(reset_i), .status_wr_i(status_wr),
    .prio_wr_i(prio_wr), .block_cmd_i(block_cmd), .irq_i(irq), .trap_i(trap),
    .cpu_level_o(cpu_level), .block_active_o(block_active), .req_o(req));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic expect_req(input logic [8:0] e);
    tick(2);
    chk("req", e, req);
  endtask : expect_req
  task automatic setp(input logic [2:0] i, input logic [2:0] p);
    prio_wr = {1'b1, i, p};
    tick(1);
    prio_wr.valid = 1'b0;
    tick(1);
  endtask : setp
  task automatic core(input logic [1:0] c, input logic [2:0] l);
    cmd = c;
    lv = l;
    tick(1);
    cmd = 2'h0;
  endtask : core
  task automatic t_reset;
    chk("level", 9'h000, {6'h00, cpu_level});
    irq = 8'h08;
    expect_req({1'b1, 1'b0, 4'h4, 3'h3});
    $display("test reset done");
  endtask : t_reset
  task automatic t_off;
    setp(3'h3, 3'h0);
    expect_req(9'h000);
    setp(3'h3, 3'h4);
    setp(3'h5, 3'h7);
    $display("test off done");
  endtask : t_off
  task automatic t_mask;
    core(2'h1, 3'h3);
    expect_req({1'b1, 1'b0, 4'h4, 3'h3});
    core(2'h1, 3'h4);
    expect_req(9'h000);
    irq = 8'h28;
    core(2'h2, 3'h0);
    expect_req(9'h000);
    chk("level", 9'h007, {6'h00, cpu_level});
    trap = 8'h81;
    expect_req({1'b1, 1'b1, 4'hF, 3'h7});
    trap = 8'h00;
    core(2'h3, 3'h0);
    expect_req({1'b1, 1'b0, 4'h7, 3'h5});
    chk("level", 9'h004, {6'h00, cpu_level});
    core(2'h1, 3'h0);
    $display("test mask done");
  endtask : t_mask
  task automatic t_block;
    irq = 8'h08;
    block_cmd = {1'b1, 14'h0004};
    tick(1);
    block_cmd.valid = 1'b0;
    chk("block", 9'h001, {8'h00, block_active});
    expect_req(9'h000);
    irq = 8'h28;
    expect_req({1'b1, 1'b0, 4'h7, 3'h5});
    irq = 8'h08;
    tick(2);
    chk("block", 9'h000, {8'h00, block_active});
    expect_req({1'b1, 1'b0, 4'h4, 3'h3});
    $display("test block done");
  endtask : t_block
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    tick(5);
    reset_i = 1'b0;
    tick(1);
    t_reset();
    t_off();
    t_mask();
    t_block();
    test_done();
  end
endmodule : tb
